// file: logic/rlmf_top.sv
/*
  Receive link monitor and framer for four channels: transition
  density, frequency range control, channel enable latch, framing,
  and the active-low link fault per channel, with a Wishbone port.
  Assumes recovered bits, character ticks and reference ticks come
  from on-chip logic on i_clk; pins are synchronised here.
*/
`timescale 1ns/1ps
module rlmf_top
  import rlmf_pkg::*;
#(
  parameter int unsigned SAMPLE_PERIOD = SAMPLE_REF_PERIODS
)(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_rx_enable_latch_open,
  input wire logic [7:0] i_channel_control_bus,
  input wire logic i_local_loopback_enable,
  input wire logic [rlmf_pkg::CHAN_N-1:0] i_amp_ok,
  input wire logic i_ref_tick,
  input wire logic [rlmf_pkg::CHAN_N-1:0] i_rec_char_tick,
  input wire logic [rlmf_pkg::CHAN_N-1:0] i_rx_bit,
  input wire logic [rlmf_pkg::CHAN_N-1:0] i_rx_bit_valid,
  output logic [rlmf_pkg::CHAN_N-1:0] o_link_fault_n,
  output logic [rlmf_pkg::CHAN_N-1:0] o_track_ref,
  output logic o_force_rate_x20,
  output logic [rlmf_pkg::CHAN_N-1:0] o_chan_enable
);
  localparam int unsigned RUN_W = 7;
  localparam int unsigned PER_W = 16;
  localparam int unsigned CNT_W = 17;

  // Tolerance in character ticks for a given expected count
  function automatic logic [CNT_W-1:0] tol_of(input int unsigned exp_cnt);
    tol_of = CNT_W'((longint'(exp_cnt) * PPM_TOL) / PPM_SCALE);
  endfunction

  function automatic logic out_of_range(input logic [CNT_W-1:0] cnt,
                                        input logic [CNT_W-1:0] exp_cnt,
                                        input logic [CNT_W-1:0] tol);
    logic [CNT_W-1:0] diff;
    diff = (cnt > exp_cnt) ? cnt - exp_cnt : exp_cnt - cnt;
    out_of_range = diff > tol;
  endfunction

  localparam logic [CNT_W-1:0] EXP_FULL = CNT_W'(SAMPLE_PERIOD);
  localparam logic [CNT_W-1:0] EXP_HALF =
    CNT_W'(SAMPLE_PERIOD * (RATE_HALF / RATE_FULL));
  localparam logic [CNT_W-1:0] TOL_FULL = tol_of(SAMPLE_PERIOD);
  localparam logic [CNT_W-1:0] TOL_HALF =
    tol_of(SAMPLE_PERIOD * (RATE_HALF / RATE_FULL));

  // Pin synchronisers
  logic [7:0] ctl_m_r;
  logic [7:0] ctl_s_r;
  logic le_m_r;
  logic le_s_r;
  logic lp_m_r;
  logic lp_s_r;
  logic [CHAN_N-1:0] amp_m_r;
  logic [CHAN_N-1:0] amp_s_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_m_r <= 8'hff;
      ctl_s_r <= 8'hff;
      le_m_r <= 1'b0;
      le_s_r <= 1'b0;
      lp_m_r <= 1'b0;
      lp_s_r <= 1'b0;
      amp_m_r <= '0;
      amp_s_r <= '0;
    end else begin
      ctl_m_r <= i_channel_control_bus;
      ctl_s_r <= ctl_m_r;
      le_m_r <= i_rx_enable_latch_open;
      le_s_r <= le_m_r;
      lp_m_r <= i_local_loopback_enable;
      lp_s_r <= lp_m_r;
      amp_m_r <= i_amp_ok;
      amp_s_r <= amp_m_r;
    end
  end

  // Registers
  logic [31:0] ctrl_r;
  logic [CHAN_N-1:0] en_r;
  logic [CHAN_N-1:0] dens_r;
  logic [CHAN_N-1:0] force_r;
  logic [CHAN_N-1:0] range_bad_r;
  logic [CHAN_N-1:0] aligned_r;
  logic frame_en;
  rlmf_fc_t fc_sel;
  logic half_rate;
  logic wb_req;

  assign frame_en = ctrl_r[CTRL_FRAME_EN];
  assign fc_sel = rlmf_fc_t'(ctrl_r[CTRL_FC_LSB +: 2]);
  assign half_rate = ctrl_r[CTRL_HALF_RATE];
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wb_req && i_wb_we && i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
      ctrl_r <= {28'h0, i_wb_dat[3:0]};
    end
  end

  // Ack one cycle after the request; unmapped reads return zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h0;
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          REG_CTRL: o_wb_dat <= ctrl_r;
          REG_STATUS: begin
            o_wb_dat[ST_FAULT_N +: CHAN_N] <= o_link_fault_n;
            o_wb_dat[ST_ENABLE +: CHAN_N] <= en_r;
            o_wb_dat[ST_DENSITY +: CHAN_N] <= dens_r;
            o_wb_dat[ST_FORCE +: CHAN_N] <= force_r;
            o_wb_dat[ST_RANGE +: CHAN_N] <= range_bad_r;
          end
          REG_FRAME: o_wb_dat[CHAN_N-1:0] <= aligned_r;
          default: o_wb_dat <= 32'h0;
        endcase
      end
    end
  end

  // Enable latch: transparent while open, holds when closed
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_r <= '1;
    end else if (le_s_r) begin
      for (int c = 0; c < CHAN_N; c++) begin
        en_r[c] <= ctl_s_r[2 * c];
      end
    end
  end

  // Shared sampling window on reference ticks
  logic [PER_W-1:0] per_cnt_r;
  logic per_end;
  assign per_end = i_ref_tick && (per_cnt_r == PER_W'(SAMPLE_PERIOD - 1));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      per_cnt_r <= '0;
    end else if (per_end) begin
      per_cnt_r <= '0;
    end else if (i_ref_tick) begin
      per_cnt_r <= per_cnt_r + PER_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_force_rate_x20 <= 1'b0;
      o_track_ref <= '0;
    end else begin
      o_force_rate_x20 <= half_rate;
      o_track_ref <= force_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHAN_N; g++) begin : g_ch
      logic char_done;
      logic char_trans;
      logic aligned;
      logic [RUN_W-1:0] run_r;
      logic prev_bit_r;
      logic [1:0] good_r;
      logic [CNT_W-1:0] rec_cnt_r;
      logic fault_n_nxt;

      rlmf_framer u_framer (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_bit(i_rx_bit[g]),
        .i_bit_valid(i_rx_bit_valid[g] && en_r[g]),
        .i_frame_en(frame_en),
        .i_char_sel(fc_sel),
        .o_char_done(char_done),
        .o_char_trans(char_trans),
        .o_char_data(),
        .o_aligned(aligned)
      );

      // Bits since the last transition, saturating
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          run_r <= '0;
          prev_bit_r <= 1'b0;
        end else if (i_rx_bit_valid[g] && en_r[g]) begin
          prev_bit_r <= i_rx_bit[g];
          if (i_rx_bit[g] != prev_bit_r) begin
            run_r <= '0;
          end else if (run_r <= RUN_W'(RUN_MAX_BITS)) begin
            run_r <= run_r + RUN_W'(1);
          end
        end
      end

      // Set by a long run wins over the good-character clear
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          dens_r[g] <= 1'b1;
          good_r <= 2'h0;
        end else if (run_r > RUN_W'(RUN_MAX_BITS)) begin
          dens_r[g] <= 1'b1;
          good_r <= 2'h0;
        end else if (dens_r[g] && char_done) begin
          if (!char_trans) begin
            good_r <= 2'h0;
          end else if (good_r == GOOD_CHARS - 2'h1) begin
            dens_r[g] <= 1'b0;
            good_r <= 2'h0;
          end else begin
            good_r <= good_r + 2'h1;
          end
        end
      end

      // Measure one window, force for the next, then release
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          rec_cnt_r <= '0;
          force_r[g] <= 1'b0;
          range_bad_r[g] <= 1'b0;
        end else if (!en_r[g]) begin
          rec_cnt_r <= '0;
          force_r[g] <= 1'b0;
          range_bad_r[g] <= 1'b0;
        end else if (per_end) begin
          rec_cnt_r <= '0;
          if (force_r[g]) begin
            force_r[g] <= 1'b0;
          end else begin
            range_bad_r[g] <= half_rate ?
              out_of_range(rec_cnt_r, EXP_HALF, TOL_HALF) :
              out_of_range(rec_cnt_r, EXP_FULL, TOL_FULL);
            force_r[g] <= half_rate ?
              out_of_range(rec_cnt_r, EXP_HALF, TOL_HALF) :
              out_of_range(rec_cnt_r, EXP_FULL, TOL_FULL);
          end
        end else if (i_rec_char_tick[g] && rec_cnt_r != '1) begin
          rec_cnt_r <= rec_cnt_r + CNT_W'(1);
        end
      end

      // Loopback drops the amplitude term
      assign fault_n_nxt = en_r[g] && !dens_r[g] && !force_r[g] &&
        !range_bad_r[g] && (lp_s_r || amp_s_r[g]);

      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_link_fault_n[g] <= 1'b0;
          o_chan_enable[g] <= 1'b1;
          aligned_r[g] <= 1'b0;
        end else begin
          o_link_fault_n[g] <= fault_n_nxt;
          o_chan_enable[g] <= en_r[g];
          aligned_r[g] <= aligned_r[g] | aligned;
        end
      end

      a_disabled_fault: assert property (@(posedge i_clk)
        disable iff (!i_resetn) !en_r[g] |=> !o_link_fault_n[g])
        else $error("disabled channel not faulted");
      a_forced_fault: assert property (@(posedge i_clk)
        disable iff (!i_resetn) force_r[g] |=> !o_link_fault_n[g])
        else $error("fault not low while forced");
      a_run_sets_fault: assert property (@(posedge i_clk)
        disable iff (!i_resetn) run_r > RUN_W'(RUN_MAX_BITS) |=> dens_r[g])
        else $error("long run did not set fault");
      a_density_hold: assert property (@(posedge i_clk)
        disable iff (!i_resetn) dens_r[g] && !char_done |=> dens_r[g])
        else $error("density fault cleared early");
      a_force_window: assert property (@(posedge i_clk)
        disable iff (!i_resetn) $fell(force_r[g]) && $past(en_r[g]) |->
          $past(per_end))
        else $error("force released off window");
      a_valid_cause: assert property (@(posedge i_clk)
        disable iff (!i_resetn) o_link_fault_n[g] |->
          $past(en_r[g] && !dens_r[g] && !force_r[g]))
        else $error("valid without all monitors");
      a_track_follow: assert property (@(posedge i_clk)
        disable iff (!i_resetn) force_r[g] |=> o_track_ref[g])
        else $error("loop not tracking reference");
      c_force: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(force_r[g]));
      c_recover: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(dens_r[g]));
    end
  endgenerate

  a_latch_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !le_s_r |=> $stable(en_r))
    else $error("enable latch moved while closed");
  a_latch_pass: assert property (@(posedge i_clk) disable iff (!i_resetn)
    le_s_r |=> en_r[0] == $past(ctl_s_r[0]))
    else $error("open latch did not pass enable");
  a_window_wrap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    per_end |=> per_cnt_r == '0)
    else $error("sampling window did not wrap");
  c_latch_close: cover property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(le_s_r));
endmodule

// file: logic/rlmf_pkg.sv
/*
  Shared constants for the receive link monitor and framer.
  Assumes one 100 MHz clock and a classic Wishbone register port.
*/
package rlmf_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CHAN_N = 4;
  localparam int unsigned CHAR_BITS = 10;
  // Transition density limit in bits and good-character run to clear
  localparam int unsigned RUN_MAX_BITS = 60;
  localparam logic [1:0] GOOD_CHARS = 2'h3;
  // Frequency window
  localparam int unsigned SAMPLE_REF_PERIODS = 16000;
  localparam int unsigned PPM_TOL = 1500;
  localparam int unsigned PPM_SCALE = 1000000;
  localparam int unsigned RATE_FULL = 10;
  localparam int unsigned RATE_HALF = 20;
  // Framing character select levels
  typedef enum logic [1:0] {
    RLMF_FC_TEST,
    RLMF_FC_COMMA,
    RLMF_FC_K285
  } rlmf_fc_t;
  localparam logic [7:0] COMMA_POS = 8'h3e;
  localparam logic [7:0] COMMA_NEG = 8'hc1;
  localparam logic [9:0] K285_NEG = 10'h0fa;
  localparam logic [9:0] K285_POS = 10'h305;
  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FRAME = 4'h8;
  // CTRL fields
  localparam int unsigned CTRL_FRAME_EN = 0;
  localparam int unsigned CTRL_FC_LSB = 1;
  localparam int unsigned CTRL_HALF_RATE = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  // STATUS fields, each CHAN_N wide
  localparam int unsigned ST_FAULT_N = 0;
  localparam int unsigned ST_ENABLE = 4;
  localparam int unsigned ST_DENSITY = 8;
  localparam int unsigned ST_FORCE = 12;
  localparam int unsigned ST_RANGE = 16;
endpackage

// file: logic/rlmf_framer.sv
/*
  One channel's bit-serial framer: shifts recovered bits, finds the
  selected framing character and emits framed characters.
  Assumes bits arrive from the recovery loop on the same clock.
*/
`timescale 1ns/1ps
module rlmf_framer
  import rlmf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_bit,
  input wire logic i_bit_valid,
  input wire logic i_frame_en,
  input wire rlmf_pkg::rlmf_fc_t i_char_sel,
  output logic o_char_done,
  output logic o_char_trans,
  output logic [9:0] o_char_data,
  output logic o_aligned
);
  logic [9:0] sr_r;
  logic [9:0] sr_nxt;
  logic [3:0] cnt_r;
  logic prev_r;
  logic trans_r;
  logic trans_nxt;
  logic match;

  assign sr_nxt = {sr_r[8:0], i_bit};
  assign trans_nxt = trans_r | (i_bit != prev_r);

  // Test level matches nothing
  always_comb begin
    case (i_char_sel)
      RLMF_FC_COMMA: match = (sr_nxt[9:2] == COMMA_POS) ||
                             (sr_nxt[9:2] == COMMA_NEG);
      RLMF_FC_K285: match = (sr_nxt == K285_NEG) ||
                            (sr_nxt == K285_POS);
      default: match = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sr_r <= 10'h000;
      prev_r <= 1'b0;
    end else if (i_bit_valid) begin
      sr_r <= sr_nxt;
      prev_r <= i_bit;
    end
  end

  // Pattern found on any bit position restarts the boundary
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 4'h0;
      trans_r <= 1'b0;
      o_char_done <= 1'b0;
      o_char_trans <= 1'b0;
      o_char_data <= 10'h000;
      o_aligned <= 1'b0;
    end else begin
      o_char_done <= 1'b0;
      o_aligned <= 1'b0;
      if (i_bit_valid) begin
        if ((i_frame_en && match) ||
            (cnt_r == 4'(CHAR_BITS - 1))) begin
          cnt_r <= 4'h0;
          trans_r <= 1'b0;
          o_char_done <= 1'b1;
          o_char_trans <= trans_nxt;
          o_char_data <= sr_nxt;
          o_aligned <= i_frame_en && match;
        end else begin
          cnt_r <= cnt_r + 4'h1;
          trans_r <= trans_nxt;
        end
      end
    end
  end

  a_frame_restart: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_bit_valid && i_frame_en && match |=> o_aligned && cnt_r == 4'h0)
    else $error("framer did not restart on match");
  a_k285_exact: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_char_sel == RLMF_FC_K285 && match |->
      sr_nxt == K285_NEG || sr_nxt == K285_POS)
    else $error("partial pattern matched in full mode");
  a_test_nomatch: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_char_sel == RLMF_FC_TEST |-> !match)
    else $error("reserved select matched");
  c_frame_align: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_aligned);
endmodule

// file: bench/rlmf_tx_model.sv
/*
  Far-end transmitter and reference source for the link monitor.
  Assumes the bench clock; one bit per clock, ten clocks per
  reference tick, character spacing set by the bench.
*/
`timescale 1ns/1ps
module rlmf_tx_model
  import rlmf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_stream_on,
  input wire logic i_stuck_val,
  input wire logic [3:0] i_char_gap,
  output logic [rlmf_pkg::CHAN_N-1:0] o_bit,
  output logic [rlmf_pkg::CHAN_N-1:0] o_bit_valid,
  output logic [rlmf_pkg::CHAN_N-1:0] o_char_tick,
  output logic o_ref_tick
);
  localparam logic [19:0] PAIR = {K285_NEG, K285_POS};
  logic [4:0] bit_idx_r;
  logic [3:0] ref_cnt_r;
  logic [3:0] chr_cnt_r;

  // Index runs on while stuck, so char boundaries never move
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_idx_r <= 5'h0;
      o_bit_valid <= '0;
      o_bit <= '0;
    end else begin
      bit_idx_r <= (bit_idx_r == 5'h13) ? 5'h0 : bit_idx_r + 5'h1;
      o_bit_valid <= '1;
      o_bit <= {CHAN_N{i_stream_on ? PAIR[5'h13 - bit_idx_r] :
                        i_stuck_val}};
    end
  end

  // Same ref rate as the far end: gap 10 gives an exact count
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ref_cnt_r <= 4'h0;
      chr_cnt_r <= 4'h0;
      o_ref_tick <= 1'b0;
      o_char_tick <= '0;
    end else begin
      ref_cnt_r <= (ref_cnt_r == 4'h9) ? 4'h0 : ref_cnt_r + 4'h1;
      chr_cnt_r <= (chr_cnt_r >= i_char_gap - 4'h1) ? 4'h0 :
                   chr_cnt_r + 4'h1;
      o_ref_tick <= (ref_cnt_r == 4'h9);
      o_char_tick <= {CHAN_N{chr_cnt_r == 4'h0}};
    end
  end
endmodule

// file: bench/testbench.sv
/*
  Self-checking bench for the receive link monitor and framer.
  Assumes rlmf_top and the transmitter model; Wishbone classic.
*/
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin \
  failures++; $display("wrong value at %0t: %s", $time, msg); end end
module testbench;
  import rlmf_pkg::*;
  localparam int SP = 100;
  logic clk, resetn, cyc, stb, we, ack, latch, local_loopback_enable, x20;
  logic stream_on, stuck_val, ref_tick;
  logic [3:0] adr, sel, gap, amp_ok, ctk, bits, bval, fault_n, trk, en;
  logic [7:0] bus, r;
  logic [31:0] wdat, rdat, q;
  int failures, tests_run, cycles, n;

  rlmf_top #(.SAMPLE_PERIOD(SP)) uut (.i_clk(clk), .i_resetn(resetn),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rx_enable_latch_open(latch), .i_channel_control_bus(bus),
    .i_local_loopback_enable(local_loopback_enable), .i_amp_ok(amp_ok),
    .i_ref_tick(ref_tick), .i_rec_char_tick(ctk), .i_rx_bit(bits),
    .i_rx_bit_valid(bval), .o_link_fault_n(fault_n), .o_track_ref(trk),
    .o_force_rate_x20(x20), .o_chan_enable(en));
  rlmf_tx_model tx (.i_clk(clk), .i_resetn(resetn),
    .i_stream_on(stream_on), .i_stuck_val(stuck_val), .i_char_gap(gap),
    .o_bit(bits), .o_bit_valid(bval), .o_char_tick(ctk),
    .o_ref_tick(ref_tick));

  function automatic logic [3:0] exp_en(input logic [7:0] b);
    return {b[6], b[4], b[2], b[0]};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Holds the request until ack is sampled high at an edge
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_trk(input logic [3:0] v);
    n = 0;
    while (trk !== v && n < 2500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2500) failures++;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("wrong value at %0t: run too long", $time);
      end_sim();
    end
  end

  initial begin
    {resetn, cyc, stb, we, local_loopback_enable, stuck_val} = '0;
    {adr, sel, wdat} = '0;
    {failures, tests_run, cycles} = '0;
    latch = 1'b1;
    bus = 8'hff;
    amp_ok = 4'hf;
    gap = 4'ha;
    stream_on = 1'b1;
    void'($urandom(53));
    repeat (3) @(posedge clk);
    `CHK({fault_n, trk, en}, 12'h00f, "reset outputs")
    resetn <= 1'b1;
    // Valid stream: lock inside the first window
    repeat (3 * SP * 10) @(posedge clk);
    `CHK(fault_n, 4'hf, "no lock on clean stream")
    `CHK(trk, 4'h0, "loop forced on clean stream")
    wb(1'b0, REG_FRAME, 32'h0, 4'hf);
    `CHK(q[3:0], 4'hf, "framing never found")
    wb(1'b0, REG_CTRL, 32'h0, 4'hf);
    `CHK(q, CTRL_RESET, "ctrl reset value")
    wb(1'b1, REG_CTRL, 32'h0, 4'he);
    wb(1'b0, REG_CTRL, 32'h0, 4'hf);
    `CHK(q, CTRL_RESET, "ctrl written without lane 0")
    wb(1'b1, REG_STATUS, 32'hffff_ffff, 4'hf);
    wb(1'b0, REG_STATUS, 32'h0, 4'hf);
    `CHK(q[7:0], 8'hff, "status fault and enable")
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(q, 32'h0, "unmapped read")
    $display("test registers done");
    // Stuck line: under 60 bits no fault, beyond it fault
    stuck_val <= 1'($urandom);
    stream_on <= 1'b0;
    repeat (50) @(posedge clk);
    `CHK(fault_n, 4'hf, "fault before 60 bits")
    repeat (20) @(posedge clk);
    `CHK(fault_n, 4'h0, "no fault after 60 bits")
    stream_on <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(fault_n, 4'h0, "fault cleared before three chars")
    repeat (60) @(posedge clk);
    `CHK(fault_n, 4'hf, "fault kept after three chars")
    $display("test density done");
    // Fast characters: forced for exactly one window
    gap <= 4'h9;
    wait_trk(4'hf);
    `CHK(trk, 4'hf, "loop not forced")
    gap <= 4'ha;
    @(posedge clk);
    `CHK(fault_n, 4'h0, "fault high while forced")
    wait_trk(4'h0);
    `CHK(n > SP * 10 - 6 && n < SP * 10 + 6, 1'b1, "force span")
    // Range bad holds valid low until the next compare
    repeat (SP * 12) @(posedge clk);
    `CHK(fault_n, 4'hf, "no relock")
    // Half rate expects twice the count, so this stream is out
    wb(1'b1, REG_CTRL, 32'h0000_000b, 4'hf);
    repeat (2) @(posedge clk);
    `CHK(x20, 1'b1, "half rate forcing")
    wait_trk(4'hf);
    `CHK(trk, 4'hf, "half rate not forced")
    wb(1'b1, REG_CTRL, CTRL_RESET, 4'hf);
    repeat (3 * SP * 10) @(posedge clk);
    `CHK({x20, fault_n}, 5'h0f, "full rate relock")
    $display("test range done");
    // No bonding here, so any channel may be turned off
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      latch <= 1'b1;
      bus <= r;
      repeat (8) @(posedge clk);
      `CHK(en, exp_en(r), "open latch")
      `CHK(fault_n & ~exp_en(r), 4'h0, "disabled shows ok")
      latch <= 1'b0;
      repeat (8) @(posedge clk);
      bus <= ~r;
      repeat (8) @(posedge clk);
      `CHK(en, exp_en(r), "closed latch")
    end
    latch <= 1'b1;
    bus <= 8'hff;
    // Partial window is forced once; wait for relock
    repeat (4 * SP * 10) @(posedge clk);
    `CHK(fault_n, 4'hf, "re-enabled channels")
    $display("test enable done");
    amp_ok <= 4'($urandom) & 4'h7;
    repeat (8) @(posedge clk);
    `CHK(fault_n[3], 1'b0, "low amplitude accepted")
    local_loopback_enable <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(fault_n, 4'hf, "loopback used amplitude")
    $display("test loopback done");
    end_sim();
  end
endmodule
